// [rtl/pwc_capture_timer.sv]
/*
 One capture/compare channel of a 16-bit timer: counter, two general
 registers, edge-selected input capture with optional counter clear,
 sticky flags with a mask, and an AHB-Lite register slave.
 Assumes one clock, a single AHB-Lite master doing word transfers, and a
 capture pin asynchronous to CLK_SYS.
*/
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
// What this block does
// - A 16-bit read/write counter, zero after reset and in standby.
// - A run bit starts or stops the counter.
// - The counter control register is written only while stopped.
// - The initial output level shows on the pin only while stopped.
// - An I/O control register steers both general registers, per mode.
// - Each general register acts as capture or compare register.
// - An enable register masks each interrupt source.
// - On the chosen edge the counter is copied into register A.
// - With clear-on-A selected, that capture zeroes the counter.
// - The capture edge is rising or falling; software alternates it.
// - The counter can advance on every peripheral clock.
// - Capture A sets flag A, raising the interrupt when enabled.
`timescale 1ns/1ns
`include "pwc_regs.svh"
module pwc_capture_timer (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic STANDBY,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CAPTURE_INPUT_A,
  input wire logic CAPTURE_INPUT_B,
  output logic COMPARE_OUT_A,
  output logic COMPARE_OUT_B,
  output logic CAPTURE_IRQ_A
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic counter_run_bit;
  logic [3:0] counter_control;
  pwc_pkg::pwc_mode_type operating_mode_select;
  logic [7:0] io_edge_control;
  logic [2:0] irq_enable_mask;
  logic [2:0] status;
  logic [15:0] channel_counter;
  logic [15:0] general_capture_a_value;
  logic [15:0] general_capture_b_value;
  pwc_pkg::pwc_access_type access;
  logic tick;
  logic level_a;
  logic rise_a;
  logic fall_a;
  logic level_b;
  logic rise_b;
  logic fall_b;
  logic cap_a;
  logic cap_b;
  logic cmp_a;
  logic cmp_b;
  logic wrap;
  logic clear_cnt;
  logic wr_en;
  logic rd_status;
  logic [2:0] next_status;
  logic [31:0] next_rdata;
  pwc_pkg::pwc_io_type io_a;
  pwc_pkg::pwc_io_type io_b;

  assign io_a = {io_edge_control[`PWC_IO_A_EDGE], io_edge_control[`PWC_IO_A_CAP],
                 io_edge_control[`PWC_IO_A_INIT]};
  assign io_b = {io_edge_control[`PWC_IO_B_EDGE], io_edge_control[`PWC_IO_B_CAP],
                 io_edge_control[`PWC_IO_B_INIT]};

  function automatic logic edge_hit(input pwc_pkg::pwc_io_type io, input logic r,
                                    input logic f);
    edge_hit = io.capture && (io.edge_rise_n ? f : r);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  pwc_edge_sync u_sync_a (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .pin(CAPTURE_INPUT_A),
    .level(level_a),
    .rise(rise_a),
    .fall(fall_a)
  );

  pwc_edge_sync u_sync_b (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .pin(CAPTURE_INPUT_B),
    .level(level_b),
    .rise(rise_b),
    .fall(fall_b)
  );

  pwc_prescaler u_pre (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .run(counter_run_bit),
    .sel(counter_control[`PWC_CTRL_PRE_MSB:`PWC_CTRL_PRE_LSB]),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Capture and compare events

  // Captures only count while running; a stopped counter has nothing to hold
  assign cap_a = counter_run_bit && edge_hit(io_a, rise_a, fall_a);
  assign cap_b = counter_run_bit && edge_hit(io_b, rise_b, fall_b);
  assign cmp_a = tick && !io_a.capture && channel_counter == general_capture_a_value;
  assign cmp_b = tick && !io_b.capture && channel_counter == general_capture_b_value;
  assign wrap = tick && channel_counter == 16'hFFFF;

  always_comb begin
    unique case (pwc_pkg::pwc_clear_type'(counter_control[`PWC_CTRL_CLR_MSB:`PWC_CTRL_CLR_LSB]))
      pwc_pkg::PWC_CLR_CAPA: clear_cnt = cap_a || cmp_a;
      pwc_pkg::PWC_CLR_CAPB: clear_cnt = cap_b || cmp_b;
      default: clear_cnt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one wait-free data phase

  assign wr_en = access.valid && access.write;
  assign rd_status = access.valid && !access.write && access.addr == `PWC_OFS_STATUS;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      access <= '0;
    end else if (HREADY) begin
      // Byte and halfword writes are not decoded; word access only
      access.valid <= HSEL && HTRANS[1] && HSIZE == 3'h2;
      access.write <= HWRITE;
      access.addr <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (HADDR[7:0])
      `PWC_OFS_RUN: next_rdata[`PWC_RUN_BIT] = counter_run_bit;
      `PWC_OFS_CTRL: next_rdata[3:0] = counter_control;
      `PWC_OFS_MODE: next_rdata[1:0] = operating_mode_select;
      `PWC_OFS_IOCTL: next_rdata[7:0] = io_edge_control;
      `PWC_OFS_IRQEN: next_rdata[2:0] = irq_enable_mask;
      `PWC_OFS_STATUS: next_rdata[2:0] = status;
      `PWC_OFS_COUNT: next_rdata[15:0] = channel_counter;
      `PWC_OFS_CAPA: next_rdata[15:0] = general_capture_a_value;
      `PWC_OFS_CAPB: next_rdata[15:0] = general_capture_b_value;
      `PWC_OFS_PIN: next_rdata[1:0] = {level_b, level_a};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data sampled at the address phase so it stands in the data phase
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      HRDATA <= 32'h00000000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      counter_run_bit <= 1'b0;
      irq_enable_mask <= 3'h0;
      io_edge_control <= `PWC_IO_RESET;
    end else if (wr_en) begin
      if (access.addr == `PWC_OFS_RUN) begin
        counter_run_bit <= HWDATA[`PWC_RUN_BIT];
      end
      if (access.addr == `PWC_OFS_IRQEN) begin
        irq_enable_mask <= HWDATA[2:0];
      end
      if (access.addr == `PWC_OFS_IOCTL) begin
        io_edge_control <= HWDATA[7:0];
      end
    end
  end

  // Clock source and mode ignore writes while running, so a live count is never corrupted
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      counter_control <= `PWC_CTRL_RESET;
      operating_mode_select <= pwc_pkg::PWC_MODE_NORMAL;
    end else if (wr_en && !counter_run_bit) begin
      if (access.addr == `PWC_OFS_CTRL) begin
        counter_control <= HWDATA[3:0];
      end
      if (access.addr == `PWC_OFS_MODE) begin
        operating_mode_select <= pwc_pkg::pwc_mode_type'(HWDATA[1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter and general registers

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      channel_counter <= `PWC_COUNT_RESET;
    end else if (STANDBY) begin
      channel_counter <= `PWC_COUNT_RESET;
    end else if (clear_cnt) begin
      channel_counter <= `PWC_COUNT_RESET;
    end else if (wr_en && access.addr == `PWC_OFS_COUNT) begin
      channel_counter <= HWDATA[15:0];
    end else if (tick) begin
      channel_counter <= channel_counter + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      general_capture_a_value <= `PWC_CAP_RESET;
      general_capture_b_value <= `PWC_CAP_RESET;
    end else begin
      // Capture wins over a software write in the same cycle
      if (cap_a) begin
        general_capture_a_value <= channel_counter;
      end else if (wr_en && access.addr == `PWC_OFS_CAPA) begin
        general_capture_a_value <= HWDATA[15:0];
      end
      if (cap_b) begin
        general_capture_b_value <= channel_counter;
      end else if (wr_en && access.addr == `PWC_OFS_CAPB) begin
        general_capture_b_value <= HWDATA[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags and interrupt: read clears, a new event in that cycle survives

  always_comb begin
    next_status = status;
    // Only the bits the reader saw are cleared; a flag landing on the read edge is kept
    if (rd_status) begin
      next_status = status & ~HRDATA[2:0];
    end
    next_status[`PWC_FLAG_A] = next_status[`PWC_FLAG_A] | cap_a | cmp_a;
    next_status[`PWC_FLAG_B] = next_status[`PWC_FLAG_B] | cap_b | cmp_b;
    next_status[`PWC_FLAG_OVF] = next_status[`PWC_FLAG_OVF] | wrap;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= 3'h0;
      CAPTURE_IRQ_A <= 1'b0;
    end else begin
      status <= next_status;
      CAPTURE_IRQ_A <= |(next_status & irq_enable_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare outputs: initial level held while stopped, toggle on match

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      COMPARE_OUT_A <= 1'b0;
      COMPARE_OUT_B <= 1'b0;
    end else if (!counter_run_bit) begin
      COMPARE_OUT_A <= io_a.init_level;
      COMPARE_OUT_B <= io_b.init_level;
    end else begin
      COMPARE_OUT_A <= COMPARE_OUT_A ^ cmp_a;
      COMPARE_OUT_B <= COMPARE_OUT_B ^ cmp_b;
    end
  end

endmodule

// [rtl/pwc_regs.svh]
/*
 Register offsets, field positions, reset values and timing counts of the
 pulse width capture timer. Assumes a 32-bit AHB-Lite register window.
*/
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

`define PWC_OFS_RUN 8'h00
`define PWC_OFS_CTRL 8'h04
`define PWC_OFS_MODE 8'h08
`define PWC_OFS_IOCTL 8'h0C
`define PWC_OFS_IRQEN 8'h10
`define PWC_OFS_STATUS 8'h14
`define PWC_OFS_COUNT 8'h18
`define PWC_OFS_CAPA 8'h1C
`define PWC_OFS_CAPB 8'h20
`define PWC_OFS_PIN 8'h24

`define PWC_RUN_BIT 0
`define PWC_CTRL_CLR_LSB 0
`define PWC_CTRL_CLR_MSB 1
`define PWC_CTRL_PRE_LSB 2
`define PWC_CTRL_PRE_MSB 3
`define PWC_MODE_LSB 0
`define PWC_MODE_MSB 1
`define PWC_IO_A_EDGE 0
`define PWC_IO_A_CAP 1
`define PWC_IO_A_INIT 2
`define PWC_IO_B_EDGE 4
`define PWC_IO_B_CAP 5
`define PWC_IO_B_INIT 6
`define PWC_FLAG_A 0
`define PWC_FLAG_B 1
`define PWC_FLAG_OVF 2

`define PWC_CTRL_RESET 4'h0
`define PWC_IO_RESET 8'h00
`define PWC_COUNT_RESET 16'h0000
`define PWC_CAP_RESET 16'hFFFF

`define PWC_CLK_MHZ 100
`define PWC_SYNC_STAGES 3

`endif

// [rtl/pwc_pkg.sv]
/*
 Types of the pulse width capture timer. Assumes pwc_regs.svh is in the
 include path of every file that uses the register constants.
*/
package pwc_pkg;

  typedef enum logic [1:0] {
    PWC_CLR_NONE = 2'h0,
    PWC_CLR_CAPA = 2'h1,
    PWC_CLR_CAPB = 2'h2
  } pwc_clear_type;

  typedef enum logic [1:0] {
    PWC_MODE_NORMAL = 2'h0,
    PWC_MODE_RSVD1 = 2'h1,
    PWC_MODE_RSVD2 = 2'h2,
    PWC_MODE_RSVD3 = 2'h3
  } pwc_mode_type;

  typedef enum logic [1:0] {
    PWC_BUS_IDLE = 2'h0,
    PWC_BUS_WRITE = 2'h1,
    PWC_BUS_READ = 2'h3
  } pwc_bus_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } pwc_access_type;

  typedef struct packed {
    logic edge_rise_n;
    logic capture;
    logic init_level;
  } pwc_io_type;

endpackage

// [rtl/pwc_edge_sync.sv]
/*
 Three-flop synchroniser with edge detection for the capture pin.
 Assumes the pin is asynchronous to CLK_SYS.
*/
`timescale 1ns/1ns
module pwc_edge_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic [2:0] sync;

  // Only stages 2 and 3 are looked at; stage 1 may be metastable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], pin};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (sync[1] == sync[2] && sync[2] != level) begin
        level <= sync[2];
        rise <= sync[2];
        fall <= ~sync[2];
      end
    end
  end

endmodule

// [rtl/pwc_prescaler.sv]
/*
 Counter tick generator. A divide-by-one setting ticks every clock,
 standing in for counting on every falling edge of the peripheral clock.
*/
`timescale 1ns/1ns
module pwc_prescaler (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);

  logic [5:0] div;

  function automatic logic [5:0] pwc_limit(input logic [1:0] s);
    unique case (s)
      2'h0: pwc_limit = 6'h00;
      2'h1: pwc_limit = 6'h03;
      2'h2: pwc_limit = 6'h0F;
      2'h3: pwc_limit = 6'h3F;
    endcase
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= 6'h00;
    end else if (!run || div >= pwc_limit(sel)) begin
      div <= 6'h00;
    end else begin
      div <= div + 6'h01;
    end
  end

  assign tick = run && (div >= pwc_limit(sel));

endmodule

// [tb/pwc_properties.sv]
/*
 Checker on the ports of the capture timer.
 Assumes word transfers from one AHB-Lite master.
*/
`timescale 1ns/1ns
`include "pwc_regs.svh"
module pwc_properties (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic CAPTURE_INPUT_A,
  input wire logic COMPARE_OUT_A,
  input wire logic CAPTURE_IRQ_A
);
  logic ap_wr;
  logic [7:0] ap_addr;
  logic run;
  logic [7:0] io;
  logic [2:0] mask;
  logic [2:0] wr_age;
  logic [3:0] pin_age;
  logic pin_q;
  wire logic ap = HSEL && HREADY && HTRANS[1] && HSIZE == 3'h2;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////////
  // Shadow of the registers; ages saturate so stale state is not trusted
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      run <= 1'b0;
      io <= 8'h00;
      mask <= 3'h0;
      wr_age <= 3'h0;
      pin_age <= 4'h0;
      pin_q <= 1'b0;
    end else begin
      ap_wr <= ap && HWRITE;
      ap_addr <= HADDR[7:0];
      pin_q <= CAPTURE_INPUT_A;
      pin_age <= (pin_q != CAPTURE_INPUT_A) ? 4'h0 : pin_age + {3'h0, pin_age != 4'hF};
      wr_age <= ap_wr ? 3'h0 : wr_age + {2'h0, wr_age != 3'h7};
      if (ap_wr && ap_addr == `PWC_OFS_RUN) run <= HWDATA[0];
      if (ap_wr && ap_addr == `PWC_OFS_IOCTL) io <= HWDATA[7:0];
      if (ap_wr && ap_addr == `PWC_OFS_IRQEN) mask <= HWDATA[2:0];
    end
  end
  chk_read_answer: assert property (
    ap && !HWRITE |=> HREADYOUT && !HRESP) else $error("read not answered");
  chk_write_okay: assert property (
    ap && HWRITE |=> (HREADYOUT && !HRESP) [*2]) else $error("write not okay");
  chk_upper_zero: assert property (
    ap && !HWRITE |=> HRDATA[31:16] == 16'h0000) else $error("upper read bits set");
  chk_irq_masked: assert property (
    (mask == 3'h0) [*2] |-> !CAPTURE_IRQ_A) else $error("masked irq raised");
  chk_irq_source: assert property (
    $rose(CAPTURE_IRQ_A) && mask == 3'h1 && io[1] && wr_age > 3'h2 |-> pin_age < 4'h8)
    else $error("irq without pin edge");
  chk_capture_run: assert property (
    $rose(CAPTURE_IRQ_A) && mask == 3'h1 && io[1] && wr_age > 3'h5 |-> run)
    else $error("capture while stopped");
  chk_irq_clear: assert property (
    ap && !HWRITE && HADDR[7:0] == `PWC_OFS_STATUS && mask == 3'h1 && pin_age == 4'hF
    |-> ##3 !CAPTURE_IRQ_A) else $error("irq kept after status read");
  chk_init_level: assert property (
    !run && wr_age == 3'h7 |-> COMPARE_OUT_A == io[2]) else $error("init level wrong");
endmodule
bind pwc_capture_timer pwc_properties u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .CAPTURE_INPUT_A(CAPTURE_INPUT_A), .COMPARE_OUT_A(COMPARE_OUT_A),
  .CAPTURE_IRQ_A(CAPTURE_IRQ_A));

// [tb/pwc_pulse_src.sv]
/*
 Pulse train on the capture pin.
 Assumes widths of at least 3 clocks; the pin holds its level when idle.
*/
`timescale 1ns/1ns
module pwc_pulse_src (
  input wire logic clk,
  input wire logic en,
  input wire logic [15:0] hi_w,
  input wire logic [15:0] lo_w,
  output logic pin
);
  logic [15:0] left = 16'h0001;
  initial pin = 1'b0;
  ////////////////////////////////////////////////////////////////
  // Push-pull source, so a stopped train keeps the last level
  always @(posedge clk) begin
    if (!en) begin
      left <= 16'h0001;
    end else if (left > 16'h0001) begin
      left <= left - 16'h0001;
    end else begin
      pin <= !pin;
      left <= pin ? lo_w : hi_w;
    end
  end
endmodule

// [tb/pulse_width_capture_timer_tb.sv]
/*
 Self-checking bench of the capture timer.
 Assumes the zero-wait register map of the design notes.
*/
`timescale 1ns/1ns
`include "pwc_regs.svh"
module pulse_width_capture_timer_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic standby = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [2:0] sz = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r, c;
  logic hreadyout, hresp, pin_a, cmp_a, cmp_b, irq;
  logic en = 1'b0;
  logic [15:0] hi_w = 16'h0030;
  logic [15:0] lo_w = 16'h0030;
  logic [31:0] seed = 32'hD89C2766;
  logic [7:0] io = 8'h02;
  int n_fail = 0;
  int num_checks = 0;
  always #5 clk = !clk;
  pwc_capture_timer uut (.CLK_SYS(clk), .ARST_N(arst_n), .STANDBY(standby), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .CAPTURE_INPUT_A(pin_a), .CAPTURE_INPUT_B(1'b0), .COMPARE_OUT_A(cmp_a),
    .COMPARE_OUT_B(cmp_b), .CAPTURE_IRQ_A(irq));
  pwc_pulse_src src (.clk(clk), .en(en), .hi_w(hi_w), .lo_w(lo_w), .pin(pin_a));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_cap(input logic [15:0] w);
    return {16'h0000, w - 16'h0001};
  endfunction
  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    r = hrdata;
    if (k >= 64) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 600) begin
      @(posedge clk);
      k++;
    end
    if (k >= 600) begin
      n_fail++;
      wrap_up();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(`PWC_OFS_COUNT, 1'b0, 32'h0);
    chk("count rst", 32'h0, r);
    bus(`PWC_OFS_CAPA, 1'b0, 32'h0);
    chk("capa rst", {16'h0000, `PWC_CAP_RESET}, r);
    bus(8'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h0, r);
    sz = 3'h0;
    bus(`PWC_OFS_COUNT, 1'b1, 32'h5555);
    sz = 3'h2;
    bus(`PWC_OFS_COUNT, 1'b0, 32'h0);
    chk("byte write", 32'h0, r);
    bus(`PWC_OFS_COUNT, 1'b1, 32'hFFFC);
    bus(`PWC_OFS_CTRL, 1'b1, 32'h1);
    bus(`PWC_OFS_COUNT, 1'b0, 32'h0);
    chk("count held", 32'hFFFC, r);
    bus(`PWC_OFS_RUN, 1'b1, 32'h1);
    bus(`PWC_OFS_COUNT, 1'b0, 32'h0);
    c = r;
    bus(`PWC_OFS_COUNT, 1'b0, 32'h0);
    chk("count step", {16'h0000, c[15:0] + 16'h0002}, r);
    bus(`PWC_OFS_STATUS, 1'b0, 32'h0);
    chk("wrap flag", 32'h4, r & 32'h4);
    bus(`PWC_OFS_CTRL, 1'b1, 32'hE);
    bus(`PWC_OFS_CTRL, 1'b0, 32'h0);
    chk("ctrl locked", 32'h1, r);
    bus(`PWC_OFS_MODE, 1'b1, 32'h3);
    bus(`PWC_OFS_MODE, 1'b0, 32'h0);
    chk("mode locked", 32'h0, r);
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    bus(`PWC_OFS_COUNT, 1'b0, 32'h0);
    chk("standby", 32'h0, r);
    standby <= 1'b0;
    bus(`PWC_OFS_RUN, 1'b1, 32'h0);
    bus(`PWC_OFS_IOCTL, 1'b1, 32'h44);
    repeat (8) @(posedge clk);
    chk("init level", 32'h1, {31'h0, cmp_a});
    chk("init level b", 32'h1, {31'h0, cmp_b});
    // Masked captures must leave the line low yet latch the flag
    bus(`PWC_OFS_IOCTL, 1'b1, {24'h0, io});
    bus(`PWC_OFS_RUN, 1'b1, 32'h1);
    bus(`PWC_OFS_STATUS, 1'b0, 32'h0);
    en <= 1'b1;
    repeat (70) @(posedge clk);
    en <= 1'b0;
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(`PWC_OFS_IRQEN, 1'b1, 32'h1);
    repeat (20) @(posedge clk);
    chk("irq level", 32'h1, {31'h0, irq});
    bus(`PWC_OFS_STATUS, 1'b0, 32'h0);
    chk("flag a", 32'h1, r & 32'h1);
    repeat (4) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      hi_w <= 16'h0030 + {9'h0, seed[6:0]};
      lo_w <= 16'h0030 + {9'h0, seed[14:8]};
      for (int e = 0; e < 6; e++) begin
        wait_irq();
        bus(`PWC_OFS_STATUS, 1'b0, 32'h0);
        chk("flag", 32'h1, r & 32'h1);
        bus(`PWC_OFS_CAPA, 1'b0, 32'h0);
        if (e > 0) chk("width", exp_cap(io[0] ? hi_w : lo_w), r);
        io[0] = !io[0];
        bus(`PWC_OFS_IOCTL, 1'b1, {24'h0, io});
      end
    end
    en <= 1'b0;
    wrap_up();
  end
endmodule
